/* core/hsps_delay.sv */
// Saturating delay counter: done rises after run has held for limit cycles
`timescale 1ns/1ps
module hsps_delay (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_srst,
   input  wire logic                       i_run,
   input  wire logic [hsps_pkg::CNT_W-1:0] i_limit,
   output logic                            o_done
);

   logic [hsps_pkg::CNT_W-1:0] cnt_reg;
   logic [hsps_pkg::CNT_W-1:0] cnt_next;
   logic                       done_reg;

   assign cnt_next = cnt_reg + 1'b1;

   // Dropping run restarts the measurement from zero
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst || !i_run)
      begin
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end
      else if (!done_reg)
      begin
         cnt_reg  <= cnt_next;
         done_reg <= (cnt_next >= i_limit);
      end
   end

   assign o_done = done_reg;

endmodule

/* core/hsps_sequencer.sv */
// Live-insertion power sequencer: start-up timing, soft-start, breaker and fault latch
// What this block does
// RULE1: Stay disabled until supply lockout clears
// RULE2: On/off rising starts first timing cycle
// RULE3: Timer ramps only with all nodes idle; the second cycle checks only the timer node idle
// RULE4: Timer threshold ends cycle, arms breaker, discharges
// RULE5: Gate ramp needs idle nodes, low sense, fault high
// RULE6: Soft-start fast, then slow with gate released
// RULE7: Load current flowing restores normal soft-start rate
// RULE8: Feedback high starts second timing cycle, gated
// RULE9: Second cycle end releases power-good, timer held low
// RULE10: On/off below hysteresis starts soft gate discharge
// RULE11: Feedback low drops power-good after glitch filter
// RULE12: On/off below reset level resets, strong pulldown
// RULE13: Overcurrent charges the fault integrator
// RULE14: Overcurrent blocks second timing cycle start
// RULE15: No overcurrent bleeds the fault integrator slowly
// RULE16: Integrator trip while overloaded latches off, fault
// RULE17: Latched: power-good, soft-start, gate held low
// RULE18: Long low on/off pulse clears the latch
// RULE19: New rising on/off restarts full sequence
// RULE20: Limit loop off once sense drops below limit
// RULE21: Fixed delay between trip and gate pulldown
// RULE22: Soft-start low in lockout, first cycle, fault
// RULE23: Synchronised flags, clock-counted low pulse
`timescale 1ns/1ps
module hsps_sequencer #(
   parameter logic [hsps_pkg::CNT_W-1:0] P_CLR_LOW_CYC = hsps_pkg::CLR_LOW_CYC
) (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_srst,
   input  wire hsps_pkg::hsps_cmp_s         i_cmp,
   input  wire logic                        i_psel,
   input  wire logic                        i_penable,
   input  wire logic                        i_pwrite,
   input  wire logic [hsps_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [hsps_pkg::DATA_W-1:0] i_pwdata,
   output logic      [hsps_pkg::DATA_W-1:0] o_prdata,
   output logic                             o_pready,
   output logic                             o_pslverr,
   output hsps_pkg::hsps_drv_s              o_drv,
   output logic                             o_fault_n,
   output logic                             o_supply_reset_n
);

   // ==========================================================
   // Comparator flag synchronisation
   hsps_pkg::hsps_cmp_s cmp;
   logic                on_prev_reg;

   hsps_sync #(
      .W (hsps_pkg::CMP_W)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_async    (i_cmp),
      .o_sync     (cmp)                                   // [RULE23]
   );

   // ==========================================================
   // Registers and state
   hsps_pkg::hsps_seq_e         seq_reg;
   hsps_pkg::hsps_seq_e         seq_next;
   hsps_pkg::hsps_t2_e          t2_reg;
   hsps_pkg::hsps_t2_e          t2_next;
   hsps_pkg::hsps_drv_s         drv_reg;
   hsps_pkg::hsps_drv_s         drv_next;
   logic [hsps_pkg::DATA_W-1:0] ctrl_reg;
   logic [hsps_pkg::DATA_W-1:0] prdata_reg;
   logic                        pready_reg;
   logic                        pslverr_reg;
   logic                        fault_n_reg;
   logic                        fault_n_next;
   logic                        pgood_reg;
   logic                        pgood_next;
   logic                        cb_en_reg;
   logic                        cb_en_next;
   logic                        trip_arm_reg;
   logic                        trip_arm_next;

   // ==========================================================
   // Condition decode
   wire all_idle   = cmp.timer_idle & cmp.gate_idle & cmp.filter_idle & cmp.ss_idle;
   wire on_rise    = cmp.on_turn_on & ~on_prev_reg;
   wire on_low     = ~cmp.on_reset;
   wire on_drop    = ~cmp.on_hyst;
   wire inhibit    = ctrl_reg[hsps_pkg::CTRL_INHIBIT];
   wire in_ramp    = (seq_reg == hsps_pkg::ST_SS_FAST)  ||
                     (seq_reg == hsps_pkg::ST_SS_SLOW)  ||
                     (seq_reg == hsps_pkg::ST_SS_TRACK) ||
                     (seq_reg == hsps_pkg::ST_SS_DONE);
   wire in_run     = in_ramp ||
                     (seq_reg == hsps_pkg::ST_T1_WAIT) ||
                     (seq_reg == hsps_pkg::ST_T1_RUN)  ||
                     (seq_reg == hsps_pkg::ST_RAMP_CHECK);
   wire latched    = (seq_reg == hsps_pkg::ST_LATCHED);
   wire ramp_ok    = all_idle & ~cmp.sense_cb & fault_n_reg;              // [RULE5]
   wire t2_ok      = cmp.timer_idle & ~cmp.sense_cb & fault_n_reg;        // [RULE8]
   wire trip_seen  = cb_en_reg & cmp.filter_thresh & cmp.sense_cb & ~latched;  // [RULE16]

   // ==========================================================
   // Delay counters
   logic trip_done;
   logic clr_done;
   logic glitch_done;

   // Internal delay from integrator trip to gate pulldown
   hsps_delay u_trip_delay (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_run      (trip_arm_reg),
      .i_limit    (hsps_pkg::TRIP_DELAY_CYC),
      .o_done     (trip_done)                             // [RULE21]
   );

   // Minimum low time on the on/off input that clears the latch
   hsps_delay u_clr_delay (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_run      (latched & on_low),
      .i_limit    (P_CLR_LOW_CYC),
      .o_done     (clr_done)                              // [RULE18] [RULE23]
   );

   // Feedback must stay low this long before power-good drops
   hsps_delay u_fb_glitch (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_run      (pgood_reg & ~cmp.fb_above),
      .i_limit    (hsps_pkg::FB_GLITCH_CYC),
      .o_done     (glitch_done)                           // [RULE11]
   );

   // ==========================================================
   // Main sequence
   always_comb
   begin
      seq_next = seq_reg;
      case (seq_reg)
         hsps_pkg::ST_DISABLED:
            if (cmp.uvlo_clear)
               seq_next = hsps_pkg::ST_IDLE;                               // [RULE1]
         hsps_pkg::ST_IDLE:
            if (on_rise && !inhibit)
               seq_next = hsps_pkg::ST_T1_WAIT;                            // [RULE2] [RULE19]
         hsps_pkg::ST_T1_WAIT:
            if (all_idle)
               seq_next = hsps_pkg::ST_T1_RUN;                             // [RULE3]
         hsps_pkg::ST_T1_RUN:
            if (cmp.timer_thresh)
               seq_next = hsps_pkg::ST_RAMP_CHECK;                         // [RULE4]
         hsps_pkg::ST_RAMP_CHECK:
            if (ramp_ok)
               seq_next = hsps_pkg::ST_SS_FAST;                            // [RULE5]
         hsps_pkg::ST_SS_FAST:
            if (cmp.ss_offset)
               seq_next = hsps_pkg::ST_SS_SLOW;                            // [RULE6]
         hsps_pkg::ST_SS_SLOW:
            if (cmp.load_flowing)
               seq_next = hsps_pkg::ST_SS_TRACK;                           // [RULE7]
         hsps_pkg::ST_SS_TRACK:
            if (cmp.ss_final)
               seq_next = hsps_pkg::ST_SS_DONE;                            // [RULE7]
         hsps_pkg::ST_SS_DONE:
            seq_next = hsps_pkg::ST_SS_DONE;
         hsps_pkg::ST_POWER_DOWN:
            seq_next = hsps_pkg::ST_POWER_DOWN;
         hsps_pkg::ST_LATCHED:
            if (clr_done)
               seq_next = hsps_pkg::ST_IDLE;                               // [RULE18]
         default:
            seq_next = hsps_pkg::ST_DISABLED;
      endcase
      // Turn-off paths; the reset level outranks the soft discharge
      if (in_run && on_drop)
         seq_next = hsps_pkg::ST_POWER_DOWN;                               // [RULE10]
      if ((in_run || seq_reg == hsps_pkg::ST_POWER_DOWN) && on_low)
         seq_next = hsps_pkg::ST_IDLE;                                     // [RULE12]
      // A timed-out trip wins over any on/off activity
      if (trip_done)
         seq_next = hsps_pkg::ST_LATCHED;                                  // [RULE16]
      if (!cmp.uvlo_clear)
         seq_next = hsps_pkg::ST_DISABLED;                                 // [RULE1]
   end

   // ==========================================================
   // Second timing cycle and power-good
   always_comb
   begin
      t2_next    = t2_reg;
      pgood_next = pgood_reg;
      case (t2_reg)
         hsps_pkg::T2_IDLE:
            // Overcurrent holds off the start even with feedback already high
            if (in_ramp && cmp.fb_above && !cmp.sense_cb)
               t2_next = hsps_pkg::T2_WAIT;                                // [RULE8] [RULE14]
         hsps_pkg::T2_WAIT:
            if (t2_ok)
               t2_next = hsps_pkg::T2_RUN;                                 // [RULE8]
         hsps_pkg::T2_RUN:
            if (cmp.timer_thresh)
            begin
               t2_next    = hsps_pkg::T2_DONE;
               pgood_next = 1'b1;                                          // [RULE9]
            end
         hsps_pkg::T2_DONE:
            if (glitch_done)
            begin
               t2_next    = hsps_pkg::T2_IDLE;
               pgood_next = 1'b0;                                          // [RULE11]
            end
         default:
            t2_next = hsps_pkg::T2_IDLE;
      endcase
      // Leaving the powered states ends the cycle; power-good follows the filter
      if (!in_ramp && t2_reg != hsps_pkg::T2_DONE)
         t2_next = hsps_pkg::T2_IDLE;
      if (seq_next == hsps_pkg::ST_IDLE || seq_next == hsps_pkg::ST_DISABLED ||
          seq_next == hsps_pkg::ST_LATCHED)
      begin
         t2_next    = hsps_pkg::T2_IDLE;
         pgood_next = 1'b0;                                                // [RULE17]
      end
   end

   // ==========================================================
   // Breaker, trip timing and fault latch
   always_comb
   begin
      cb_en_next    = cb_en_reg;
      trip_arm_next = trip_arm_reg;
      fault_n_next  = fault_n_reg;
      if (seq_reg == hsps_pkg::ST_T1_RUN && cmp.timer_thresh)
         cb_en_next = 1'b1;                                                // [RULE4]
      if (trip_seen)
         trip_arm_next = 1'b1;                                             // [RULE16]
      if (trip_done)
      begin
         fault_n_next  = 1'b0;                                             // [RULE16] [RULE21]
         trip_arm_next = 1'b0;
         cb_en_next    = 1'b0;
      end
      if (clr_done)
         fault_n_next = 1'b1;                                              // [RULE18]
      // A trip timing in flight is abandoned by a sequence reset
      if (seq_next == hsps_pkg::ST_IDLE || seq_next == hsps_pkg::ST_DISABLED)
      begin
         cb_en_next    = 1'b0;
         trip_arm_next = 1'b0;
      end
      if (!cmp.uvlo_clear)
         fault_n_next = 1'b1;
   end

   // ==========================================================
   // Analog drive controls
   always_comb
   begin
      drv_next = '0;
      drv_next.timer_pullup = (seq_reg == hsps_pkg::ST_T1_RUN) ||              // [RULE3]
                              (t2_reg == hsps_pkg::T2_RUN && t2_ok);           // [RULE8]
      // Quick discharge after the first cycle, held low after the second
      drv_next.timer_discharge = !drv_next.timer_pullup;                       // [RULE4] [RULE9]
      drv_next.ss_pull_norm  = (seq_reg == hsps_pkg::ST_SS_FAST)  ||
                               (seq_reg == hsps_pkg::ST_SS_TRACK) ||
                               (seq_reg == hsps_pkg::ST_SS_DONE);              // [RULE7]
      drv_next.ss_pull_slow  = (seq_reg == hsps_pkg::ST_SS_SLOW);              // [RULE6]
      drv_next.ss_pulldown   = (seq_reg == hsps_pkg::ST_DISABLED)   ||
                               (seq_reg == hsps_pkg::ST_IDLE)       ||
                               (seq_reg == hsps_pkg::ST_T1_WAIT)    ||
                               (seq_reg == hsps_pkg::ST_T1_RUN)     ||
                               (seq_reg == hsps_pkg::ST_RAMP_CHECK) ||
                               latched;                                        // [RULE22] [RULE17]
      drv_next.gate_hold_low = (seq_reg == hsps_pkg::ST_SS_FAST);              // [RULE6]
      drv_next.gate_pullup   = (seq_reg == hsps_pkg::ST_SS_SLOW)  ||
                               (seq_reg == hsps_pkg::ST_SS_TRACK) ||
                               (seq_reg == hsps_pkg::ST_SS_DONE);              // [RULE6]
      drv_next.gate_pd_soft  = (seq_reg == hsps_pkg::ST_POWER_DOWN);           // [RULE10]
      drv_next.gate_pd_strong = !in_run && !drv_next.gate_pd_soft;             // [RULE12] [RULE17]
      // Past the end of soft-start the loop only acts while at the limit
      drv_next.acl_enable    = (seq_reg == hsps_pkg::ST_SS_FAST)    ||
                               (seq_reg == hsps_pkg::ST_SS_TRACK)   ||
                               (seq_reg == hsps_pkg::ST_POWER_DOWN) ||
                               (seq_reg == hsps_pkg::ST_SS_DONE && cmp.sense_acl);  // [RULE20]
      drv_next.filter_dump   = on_low;
      drv_next.filter_charge = cb_en_reg && cmp.sense_cb && !latched && !on_low;    // [RULE13]
      drv_next.filter_bleed  = !drv_next.filter_charge && !on_low;                  // [RULE15]
      // A timed-out trip pulls gate and soft-start down at once
      if (trip_done)
      begin
         drv_next = '0;
         drv_next.gate_pd_strong  = 1'b1;                                      // [RULE16]
         drv_next.ss_pulldown     = 1'b1;                                      // [RULE22]
         drv_next.timer_discharge = 1'b1;
         drv_next.filter_bleed    = !on_low;
         drv_next.filter_dump     = on_low;
      end
   end

   // ==========================================================
   // APB slave: one wait state, write lands at the pready edge
   wire hit_ctrl   = (i_paddr == hsps_pkg::ADDR_CTRL);
   wire hit_status = (i_paddr == hsps_pkg::ADDR_STATUS);
   wire apb_access = i_psel & i_penable & ~pready_reg;
   wire apb_write  = i_psel & i_penable & pready_reg & i_pwrite & hit_ctrl;
   wire [hsps_pkg::DATA_W-1:0] status_word =
      (hsps_pkg::DATA_W'(fault_n_reg)  << hsps_pkg::ST_FAULT)    |
      (hsps_pkg::DATA_W'(pgood_reg)    << hsps_pkg::ST_PGOOD)    |
      (hsps_pkg::DATA_W'(cb_en_reg)    << hsps_pkg::ST_CB_EN)    |
      (hsps_pkg::DATA_W'(cmp.uvlo_clear) << hsps_pkg::ST_ENABLED) |
      (hsps_pkg::DATA_W'(trip_arm_reg) << hsps_pkg::ST_TRIP_ARM) |
      (hsps_pkg::DATA_W'(seq_reg)      << hsps_pkg::ST_SEQ_LSB)  |
      (hsps_pkg::DATA_W'(t2_reg)       << hsps_pkg::ST_T2_LSB);
   wire [hsps_pkg::DATA_W-1:0] rd_mux =
      hit_ctrl   ? ctrl_reg :
      hit_status ? status_word : '0;

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= '0;
         ctrl_reg    <= hsps_pkg::CTRL_RST;
      end
      else
      begin
         pready_reg  <= apb_access;
         pslverr_reg <= apb_access & ~(hit_ctrl | hit_status);
         prdata_reg  <= (apb_access & ~i_pwrite) ? rd_mux : '0;
         if (apb_write)
            ctrl_reg <= i_pwdata & (hsps_pkg::DATA_W'(1) << hsps_pkg::CTRL_INHIBIT);
      end
   end

   // ==========================================================
   // Sequencer state registers
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         seq_reg      <= hsps_pkg::ST_DISABLED;
         t2_reg       <= hsps_pkg::T2_IDLE;
         drv_reg      <= '0;
         fault_n_reg  <= 1'b1;
         pgood_reg    <= 1'b0;
         cb_en_reg    <= 1'b0;
         trip_arm_reg <= 1'b0;
         on_prev_reg  <= 1'b1;
      end
      else
      begin
         seq_reg      <= seq_next;
         t2_reg       <= t2_next;
         drv_reg      <= drv_next;
         fault_n_reg  <= fault_n_next;
         pgood_reg    <= pgood_next;
         cb_en_reg    <= cb_en_next;
         trip_arm_reg <= trip_arm_next;
         on_prev_reg  <= cmp.on_turn_on;
      end
   end

   assign o_prdata         = prdata_reg;
   assign o_pready         = pready_reg;
   assign o_pslverr        = pslverr_reg;
   assign o_drv            = drv_reg;
   assign o_fault_n        = fault_n_reg;
   assign o_supply_reset_n = pgood_reg;

endmodule

/* core/hsps_sync.sv */
// Two-flop synchroniser for the comparator flag vector
`timescale 1ns/1ps
module hsps_sync #(
   parameter int W = hsps_pkg::CMP_W
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // Only the second stage is visible to any logic
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

/* shared/hsps_pkg.sv */
// Shared constants, flag carriers and state types of the power sequencer
package hsps_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned NS_PER_S       = 1_000_000_000;
   localparam int unsigned TRIP_DELAY_NS  = 20_000;
   localparam int unsigned CLR_LOW_NS     = 100_000;
   localparam int unsigned FB_GLITCH_NS   = 2_000;
   localparam int          CNT_W          = 16;
   // Least times: round up to whole cycles
   localparam int unsigned TRIP_DELAY_CYC_I =
      (TRIP_DELAY_NS / 10 * (CLK_HZ / 100_000_000 * 0 + CLK_HZ / 1_000_000) + 99) / 100;
   localparam int unsigned CLR_LOW_CYC_I =
      (CLR_LOW_NS / 10 * (CLK_HZ / 1_000_000) + 99) / 100;
   localparam int unsigned FB_GLITCH_CYC_I =
      (FB_GLITCH_NS / 10 * (CLK_HZ / 1_000_000) + 99) / 100;
   localparam logic [CNT_W-1:0] TRIP_DELAY_CYC = CNT_W'(TRIP_DELAY_CYC_I);
   localparam logic [CNT_W-1:0] CLR_LOW_CYC    = CNT_W'(CLR_LOW_CYC_I);
   localparam logic [CNT_W-1:0] FB_GLITCH_CYC  = CNT_W'(FB_GLITCH_CYC_I);

   // ==========================================================
   // Register map
   localparam int          ADDR_W         = 8;
   localparam int          DATA_W         = 32;
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_STATUS    = 8'h04;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
   localparam int          CTRL_INHIBIT   = 0;
   localparam int          ST_FAULT       = 0;
   localparam int          ST_PGOOD       = 1;
   localparam int          ST_CB_EN       = 2;
   localparam int          ST_ENABLED     = 3;
   localparam int          ST_TRIP_ARM    = 4;
   localparam int          ST_SEQ_LSB     = 8;
   localparam int          ST_T2_LSB      = 12;

   // ==========================================================
   // Comparator flags in, analog drive controls out
   typedef struct packed {
      logic uvlo_clear;
      logic on_turn_on;
      logic on_hyst;
      logic on_reset;
      logic timer_idle;
      logic gate_idle;
      logic filter_idle;
      logic ss_idle;
      logic timer_thresh;
      logic filter_thresh;
      logic ss_offset;
      logic load_flowing;
      logic ss_final;
      logic sense_cb;
      logic sense_acl;
      logic fb_above;
   } hsps_cmp_s;

   typedef struct packed {
      logic timer_pullup;
      logic timer_discharge;
      logic ss_pull_norm;
      logic ss_pull_slow;
      logic ss_pulldown;
      logic gate_hold_low;
      logic gate_pullup;
      logic gate_pd_soft;
      logic gate_pd_strong;
      logic acl_enable;
      logic filter_charge;
      logic filter_bleed;
      logic filter_dump;
   } hsps_drv_s;

   localparam int CMP_W = $bits(hsps_cmp_s);

   typedef enum logic [3:0] {
      ST_DISABLED,
      ST_IDLE,
      ST_T1_WAIT,
      ST_T1_RUN,
      ST_RAMP_CHECK,
      ST_SS_FAST,
      ST_SS_SLOW,
      ST_SS_TRACK,
      ST_SS_DONE,
      ST_POWER_DOWN,
      ST_LATCHED
   } hsps_seq_e;

   typedef enum logic [1:0] {
      T2_IDLE,
      T2_WAIT,
      T2_RUN,
      T2_DONE
   } hsps_t2_e;

endpackage

/* test/hsps_chk_assertions.sv */
// Port assertions for the power sequencer
`timescale 1ns/1ps
module hsps_chk (
   input wire logic                i_core_clk,
   input wire logic                i_srst,
   input wire hsps_pkg::hsps_cmp_s i_cmp,
   input wire logic                i_psel,
   input wire logic                i_penable,
   input wire logic                o_pready,
   input wire hsps_pkg::hsps_drv_s o_drv,
   input wire logic                o_fault_n,
   input wire logic                o_supply_reset_n
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);
   // ==========
   // Assertions
   a_apb_answer: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late");
   a_pready_pulse: assert property (o_pready |=> !o_pready) else $error("pready long");
   a_lockout_off:
      assert property (!i_cmp.uvlo_clear [*5] |-> o_drv.ss_pulldown && !o_drv.gate_pullup)
      else $error("active in lockout");
   a_latch_off:
      assert property (!o_fault_n && !$past(o_fault_n) |-> o_drv.gate_pd_strong && !o_supply_reset_n)
      else $error("latch not held");
   a_trip_pg: assert property ($fell(o_fault_n) |=> !o_supply_reset_n) else $error("pg on");
   a_filter_excl:
      assert property (!(o_drv.filter_charge && o_drv.filter_bleed)) else $error("filter both");
   a_ss_excl:
      assert property (!(o_drv.ss_pull_norm && o_drv.ss_pull_slow)) else $error("ss both");
   a_gate_excl:
      assert property (o_drv.gate_pullup |-> !o_drv.gate_pd_soft && !o_drv.gate_pd_strong)
      else $error("gate fight");
   a_pg_glitch:
      assert property (o_supply_reset_n && i_cmp.fb_above ##1 (!i_cmp.fb_above && i_cmp.on_hyst
         && i_cmp.on_reset) [*8] |-> o_supply_reset_n) else $error("pg glitch");
   c_trip: cover property ($fell(o_fault_n));
   c_clear: cover property ($rose(o_fault_n));
   c_pgood: cover property ($rose(o_supply_reset_n));
endmodule
bind hsps_sequencer hsps_chk u_chk (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cmp(i_cmp),
   .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_drv(o_drv),
   .o_fault_n(o_fault_n), .o_supply_reset_n(o_supply_reset_n));

/* test/hsps_ctl.sv */
// System controller model driving the on/off comparator levels
`timescale 1ns/1ps
module hsps_ctl (
   input  wire logic       i_core_clk,
   input  wire logic [1:0] i_lvl,
   output logic            o_on_turn_on = 1'b0,
   output logic            o_on_hyst    = 1'b0,
   output logic            o_on_reset   = 1'b0
);
   // ==========
   // Level 0 under reset level, 1 under hysteresis, 2 under turn-on, 3 above
   always @(posedge i_core_clk)
   begin
      o_on_turn_on <= i_lvl == 2'h3;
      o_on_hyst    <= i_lvl >= 2'h2;
      o_on_reset   <= i_lvl != 2'h0;
   end
endmodule

/* test/testbench.sv */
// Self-checking bench for the power sequencer
`timescale 1ns/1ps
module testbench;
   localparam int FLT = 14, PG = 13, TPU = 12, TDIS = 11, SSN = 10, SSS = 9, SSPD = 8;
   localparam int GHL = 7, GPU = 6, GPDS = 5, GPDX = 4, ANALOG_CURRENT_LIMIT = 3, FCH = 2, FBL = 1;
   logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, rdy, se, fn, pg, on_t, on_h, on_r, qe;
   logic [7:0]  pa  = 8'h00;
   logic [31:0] pwd = 32'h0, prd, q;
   logic [1:0]  lvl = 2'h0;
   logic [14:0] w;
   hsps_pkg::hsps_cmp_s f, cmp;
   hsps_pkg::hsps_drv_s drv;
   int err_count = 0, total_checks = 0, cyc = 0;
   hsps_ctl u_ctl (.i_core_clk(clk), .i_lvl(lvl), .o_on_turn_on(on_t), .o_on_hyst(on_h),
      .o_on_reset(on_r));
   hsps_sequencer #(.P_CLR_LOW_CYC(16'h0014)) DUT (.i_core_clk(clk), .i_srst(srst), .i_cmp(cmp),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
      .o_prdata(prd), .o_pready(rdy), .o_pslverr(se), .o_drv(drv), .o_fault_n(fn),
      .o_supply_reset_n(pg));
   always #10 clk = ~clk;
   always_comb
   begin
      cmp = f;
      cmp.on_turn_on = on_t;
      cmp.on_hyst = on_h;
      cmp.on_reset = on_r;
   end
   assign w = {fn, pg, drv};
   // ==========
   // Helpers
   task print_verdict;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task ck(input int b, input logic v);
      total_checks++;
      if (w[b] !== v)
      begin
         err_count++;
         $display("CHECK FAILED out bit %0d exp %b got %b", b, v, w[b]);
      end
   endtask
   task cv(input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED apb exp %h got %h", e, g);
      end
   endtask
   task wt(input int b, input logic v);
      int n;
      n = 0;
      while (w[b] !== v && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      ck(b, v);
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr  <= wr;
      pa   <= a;
      pwd  <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (rdy !== 1'b1);
      q = prd;
      qe = se;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ==========
   // Scenarios
   task t_regs;
      apb(1'b0, hsps_pkg::ADDR_STATUS, 32'h0);
      cv(32'h0000_0001, q);
      apb(1'b0, 8'h08, 32'h0);
      cv(32'h0000_0001, {31'h0, qe});
      apb(1'b1, hsps_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, hsps_pkg::ADDR_CTRL, 32'h0);
      cv(32'h0000_0001, q);
      apb(1'b1, hsps_pkg::ADDR_CTRL, 32'h0);
   endtask
   task t_start;
      lvl <= 2'h3;
      idle(20);
      ck(TPU, 0);
      lvl <= 2'h0;
      f.uvlo_clear <= 1'b1;
      idle(10);
      lvl <= 2'h3;
      idle(20);
      ck(TPU, 0);
      f.filter_idle <= 1'b1;
      wt(TPU, 1);
      ck(SSPD, 1);
      f.timer_thresh <= 1'b1;
      f.sense_cb <= 1'b1;
      wt(TDIS, 1);
      f.timer_thresh <= 1'b0;
      idle(20);
      ck(SSN, 0);
      f.sense_cb <= 1'b0;
      wt(SSN, 1);
      ck(GHL, 1);
   endtask
   task t_power;
      f.ss_offset <= 1'b1;
      wt(SSS, 1);
      ck(GPU, 1);
      f.load_flowing <= 1'b1;
      wt(SSN, 1);
      f.ss_final <= 1'b1;
      f.sense_cb <= 1'b1;
      f.sense_acl <= 1'b1;
      f.fb_above <= 1'b1;
      wt(ANALOG_CURRENT_LIMIT, 1);
      idle(20);
      ck(TPU, 0);
      f.sense_acl <= 1'b0;
      f.sense_cb <= 1'b0;
      wt(ANALOG_CURRENT_LIMIT, 0);
      wt(FBL, 1);
      wt(TPU, 1);
      f.timer_thresh <= 1'b1;
      wt(PG, 1);
      idle(1);
      ck(TPU, 0);
      f.timer_thresh <= 1'b0;
      f.fb_above <= 1'b0;
      idle(80);
      ck(PG, 1);
      wt(PG, 0);
      lvl <= 2'h1;
      wt(GPDS, 1);
      lvl <= 2'h0;
      wt(GPDX, 1);
      f.ss_offset <= 1'b0;
      f.load_flowing <= 1'b0;
      f.ss_final <= 1'b0;
   endtask
   task t_trip;
      lvl <= 2'h3;
      wt(TPU, 1);
      f.timer_thresh <= 1'b1;
      wt(TDIS, 1);
      f.timer_thresh <= 1'b0;
      wt(SSN, 1);
      f.sense_cb <= 1'b1;
      wt(FCH, 1);
      f.filter_thresh <= 1'b1;
      idle(900);
      ck(FLT, 1);
      wt(FLT, 0);
      ck(GPDX, 1);
      f.sense_cb <= 1'b0;
      f.filter_thresh <= 1'b0;
      lvl <= 2'h0;
      idle(10);
      lvl <= 2'h3;
      idle(40);
      ck(FLT, 0);
      ck(TPU, 0);
      lvl <= 2'h0;
      wt(FLT, 1);
      lvl <= 2'h3;
      wt(TPU, 1);
   endtask
   // ==========
   // Main sequence and hang guard
   initial
   begin
      f = 16'h0D00;
      idle(12);
      srst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_start;
      t_power;
      t_trip;
      print_verdict;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         print_verdict;
      end
   end
endmodule
